/* File: bench/slp_keypad_model.sv */
// Operator keypad model: held-key requests become key levels.
// Assumes requests are made in the I_MCLK domain.
`timescale 1ns/1ps
module slp_keypad_model (
   input  wire logic       i_clk,
   input  wire logic [3:0] i_hold,
   output logic      [3:0] o_key
);
   // Keys change a cycle late, as a real panel never lines up with scans
   always @(posedge i_clk) begin
      o_key <= i_hold;
   end
endmodule

/* File: bench/slp_top_assertions.sv */
// Checker for the scan primitives, bound to slp_top.
// Assumes one I_MCLK domain and synchronous high I_RESET.
`timescale 1ns/1ps
module slp_top_chk #(
   parameter GROUPS = 8,
   parameter GW     = 3,
   parameter KEYS   = 4
) (
   input wire logic                   I_MCLK, I_RESET, I_SCAN,
   input wire logic                   I_COLD_START, I_WARM_START,
   input wire logic                   I_SEL_A, I_SEL_B, I_TRIG_IN,
   input wire logic                   I_CHOOSE_FIRST_INPUT,
   input wire logic                   I_LATCH_SET, I_LATCH_CLR, I_TOG_RST,
   input wire logic [GW-1:0]          I_KEY_GROUP,
   input wire logic                   O_SEL_OUT, O_TRIG_OUT, O_STRIG_OUT,
   input wire logic                   O_LATCH_OUT, O_TOG_OUT, O_EXPR_OUT,
   input wire logic [GROUPS*KEYS-1:0] O_KEY_PULSE
);
   wire st = I_RESET | I_COLD_START | I_WARM_START;
   wire ok = I_SCAN & ~st;
   wire [GROUPS*KEYS+5:0] outs = {O_KEY_PULSE, O_SEL_OUT, O_TRIG_OUT,
      O_STRIG_OUT, O_LATCH_OUT, O_TOG_OUT, O_EXPR_OUT};
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_RESET);
   AST_SEL: assert property ($past(ok) |->
      O_SEL_OUT == $past(I_CHOOSE_FIRST_INPUT ? I_SEL_A : I_SEL_B))
      else $error("selector output wrong");
   AST_TRIG_ONE: assert property (O_TRIG_OUT && ok |=> !O_TRIG_OUT)
      else $error("one-shot longer than a scan");
   AST_TRIG_WHY: assert property ($rose(O_TRIG_OUT) |->
      $past(ok && I_TRIG_IN)) else $error("one-shot without input");
   AST_HOLD: assert property (!$past(I_SCAN) && !$past(st) |->
      $stable(outs)) else $error("output moved between scans");
   AST_START: assert property ($past(st) |-> outs == 0)
      else $error("output not cleared on start");
   AST_LSET: assert property ($past(ok && I_LATCH_SET) |->
      O_LATCH_OUT) else $error("latch not set");
   AST_LCLR: assert property ($past(ok && I_LATCH_CLR && !I_LATCH_SET)
      |-> !O_LATCH_OUT) else $error("latch not cleared");
   AST_LHOLD: assert property ($past(ok && !I_LATCH_SET && !I_LATCH_CLR)
      |-> $stable(O_LATCH_OUT)) else $error("latch did not hold");
   AST_TRST: assert property ($past(ok && I_TOG_RST) |-> !O_TOG_OUT)
      else $error("toggle reset ignored");
   AST_KEY: assert property ($past(ok) |-> (O_KEY_PULSE &
      ~({{GROUPS*KEYS-KEYS{1'b0}}, {KEYS{1'b1}}}
      << KEYS*$past(I_KEY_GROUP))) == 0)
      else $error("key pulse outside chosen group");
   cover property ($rose(O_LATCH_OUT));
   cover property ($rose(O_STRIG_OUT));
   cover property (|O_KEY_PULSE);
endmodule
bind slp_top slp_top_chk #(.GROUPS(GROUPS), .GW(GW), .KEYS(KEYS))
   i_slp_top_chk (
   .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_SCAN(I_SCAN),
   .I_COLD_START(I_COLD_START), .I_WARM_START(I_WARM_START),
   .I_SEL_A(I_SEL_A), .I_SEL_B(I_SEL_B), .I_TRIG_IN(I_TRIG_IN),
   .I_CHOOSE_FIRST_INPUT(I_CHOOSE_FIRST_INPUT),
   .I_LATCH_SET(I_LATCH_SET), .I_LATCH_CLR(I_LATCH_CLR),
   .I_TOG_RST(I_TOG_RST), .I_KEY_GROUP(I_KEY_GROUP),
   .O_SEL_OUT(O_SEL_OUT), .O_TRIG_OUT(O_TRIG_OUT),
   .O_STRIG_OUT(O_STRIG_OUT), .O_LATCH_OUT(O_LATCH_OUT),
   .O_TOG_OUT(O_TOG_OUT), .O_EXPR_OUT(O_EXPR_OUT),
   .O_KEY_PULSE(O_KEY_PULSE));

/* File: bench/slp_top_tb.sv */
// Self-checking bench for slp_top.
// Assumes the keypad model drives the function keys.
`timescale 1ns/1ps
module slp_top_tb;
   logic        I_MCLK = 0, I_RESET = 1, I_SCAN = 0, I_COLD_START = 0;
   logic        I_WARM_START = 0, I_SEL_A = 0, I_SEL_B = 0, I_TRIG_IN = 0;
   logic        I_CHOOSE_FIRST_INPUT = 0, I_STRIG_IN = 0, I_TOG_IN = 0;
   logic        I_LATCH_SET = 0, I_LATCH_CLR = 0, I_TOG_RST = 0;
   logic [1:0]  I_STRIG_EDGE = 0, I_STRIG_START = 0;
   logic [7:0]  I_EXPR_IN = 0;
   logic [13:0] I_EXPR_OP = 0;
   logic [27:0] I_EXPR_SRC_A = 0, I_EXPR_SRC_B = 0;
   logic [3:0]  I_FUNCTION_KEY, hold = 0;
   logic [2:0]  I_KEY_GROUP = 0;
   logic        O_SEL_OUT, O_TRIG_OUT, O_STRIG_OUT, O_LATCH_OUT;
   logic        O_TOG_OUT, O_EXPR_OUT;
   logic [31:0] O_KEY_PULSE;
   int          n_fail = 0, comparisons = 0;
   always #50 I_MCLK = ~I_MCLK;
   slp_top i_slp_top (
      .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_SCAN(I_SCAN),
      .I_COLD_START(I_COLD_START), .I_WARM_START(I_WARM_START),
      .I_SEL_A(I_SEL_A), .I_SEL_B(I_SEL_B),
      .I_CHOOSE_FIRST_INPUT(I_CHOOSE_FIRST_INPUT), .O_SEL_OUT(O_SEL_OUT),
      .I_TRIG_IN(I_TRIG_IN), .O_TRIG_OUT(O_TRIG_OUT),
      .I_STRIG_IN(I_STRIG_IN), .I_STRIG_EDGE(I_STRIG_EDGE),
      .I_STRIG_START(I_STRIG_START), .O_STRIG_OUT(O_STRIG_OUT),
      .I_LATCH_SET(I_LATCH_SET), .I_LATCH_CLR(I_LATCH_CLR),
      .O_LATCH_OUT(O_LATCH_OUT), .I_TOG_IN(I_TOG_IN),
      .I_TOG_RST(I_TOG_RST), .O_TOG_OUT(O_TOG_OUT),
      .I_EXPR_IN(I_EXPR_IN), .I_EXPR_OP(I_EXPR_OP),
      .I_EXPR_SRC_A(I_EXPR_SRC_A), .I_EXPR_SRC_B(I_EXPR_SRC_B),
      .O_EXPR_OUT(O_EXPR_OUT), .I_FUNCTION_KEY(I_FUNCTION_KEY),
      .I_KEY_GROUP(I_KEY_GROUP), .O_KEY_PULSE(O_KEY_PULSE));
   slp_keypad_model i_slp_keypad_model (.i_clk(I_MCLK), .i_hold(hold),
      .o_key(I_FUNCTION_KEY));
   task scan;
      I_SCAN <= 1;
      @(posedge I_MCLK) I_SCAN <= 0;
      @(posedge I_MCLK);
   endtask
   task chk(string nm, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task summarize;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task t_sel;
      for (int i = 0; i < 4; i++) begin
         {I_CHOOSE_FIRST_INPUT, I_SEL_A} <= i[1:0];
         I_SEL_B <= ~i[0];
         scan;
         chk("sel", i[1] ? i[0] : !i[0], O_SEL_OUT);
      end
   endtask
   task t_trig;
      I_TRIG_IN <= 1;
      scan;
      chk("trig", 1, O_TRIG_OUT);
      scan;
      chk("trig", 0, O_TRIG_OUT);
   endtask
   task t_strig;
      for (int e = 0; e < 4; e++) begin
         I_STRIG_EDGE <= e[1:0];
         scan;
         I_STRIG_IN <= 1;
         scan;
         chk("rise", !e[0], O_STRIG_OUT);
         scan;
         chk("once", 0, O_STRIG_OUT);
         I_STRIG_IN <= 0;
         scan;
         chk("fall", e[0] ^ e[1], O_STRIG_OUT);
      end
   endtask
   // Input stays low, so any firing comes from the start-up option
   task t_start;
      I_STRIG_EDGE <= 2'h0;
      for (int i = 0; i < 8; i++) begin
         I_STRIG_START <= i[1:0];
         {I_WARM_START, I_COLD_START} <= {i[2], !i[2]};
         @(posedge I_MCLK) {I_WARM_START, I_COLD_START} <= 2'h0;
         scan;
         chk("start", i[2] ? i[1] : i[0], O_STRIG_OUT);
      end
   endtask
   task t_latch;
      logic [17:0] t = 18'h2_9E87;
      for (int i = 17; i > 0; i -= 3) begin
         {I_LATCH_SET, I_LATCH_CLR} <= t[i-:2];
         scan;
         chk("latch", t[i-2], O_LATCH_OUT);
      end
   endtask
   task t_tog;
      logic [20:0] t = 21'h16_982E;
      for (int i = 20; i > 0; i -= 3) begin
         {I_TOG_IN, I_TOG_RST} <= t[i-:2];
         scan;
         chk("toggle", t[i-2], O_TOG_OUT);
      end
   endtask
   // Mid-run reset clears outputs before any further scan
   task t_rst;
      I_RESET <= 1;
      @(posedge I_MCLK) I_RESET <= 0;
      @(posedge I_MCLK);
      chk("reset", 0, {O_SEL_OUT, O_LATCH_OUT, O_TOG_OUT, O_EXPR_OUT});
   endtask
   task t_expr;
      I_EXPR_OP <= 14'h00E4;
      I_EXPR_SRC_A <= 28'hBBB_A980;
      I_EXPR_SRC_B <= 28'hBBB_0321;
      for (int i = 0; i < 16; i++) begin
         I_EXPR_IN <= {~i[3:0], i[3:0]};
         scan;
         chk("expr", !(((i[0] & i[1]) | i[2]) ^ i[3]), O_EXPR_OUT);
      end
   endtask
   task t_keys;
      for (int g = 0; g < 8; g++) begin
         I_KEY_GROUP <= g[2:0];
         hold <= 4'h1 << g[1:0];
         @(posedge I_MCLK);
         scan;
         chk("key", 32'h1 << (g * 4 + g % 4), O_KEY_PULSE);
         scan;
         chk("key held", 0, O_KEY_PULSE);
         hold <= 4'h0;
         @(posedge I_MCLK);
         scan;
      end
   endtask
   initial begin
      repeat (5) @(posedge I_MCLK);
      I_RESET <= 0;
      @(posedge I_MCLK);
      t_sel;
      t_trig;
      t_strig;
      t_start;
      t_latch;
      t_tog;
      t_rst;
      t_expr;
      t_keys;
      summarize;
   end
   initial begin
      repeat (2000) @(posedge I_MCLK);
      n_fail++;
      summarize;
   end
endmodule

/* File: verilog/slp_consts.vh */
// Constants for the scan logic primitive set.
// Included by the top-level design file only; definitions only.
`ifndef SLP_CONSTS_VH
`define SLP_CONSTS_VH
`define SLP_EDGE_RISE     2'h0
`define SLP_EDGE_FALL     2'h1
`define SLP_EDGE_BOTH     2'h2
`define SLP_START_NONE    2'h0
`define SLP_START_COLD    2'h1
`define SLP_START_WARM    2'h2
`define SLP_START_ANY     2'h3
`define SLP_OP_AND        2'h0
`define SLP_OP_OR         2'h1
`define SLP_OP_XOR        2'h2
`define SLP_OP_NOTA       2'h3
`define SLP_KEY_GROUPS    8
`define SLP_GRP_W         3
`define SLP_KEYS          4
`define SLP_EXPR_INS      8
`define SLP_VAL_W         16
`endif

/* File: verilog/slp_edge.v */
// Scan-enabled edge detector with previous-value store.
// Assumes the scan enable is a one-cycle pulse in the I_MCLK domain.
`timescale 1ns/1ps
module slp_edge #(
   parameter W = 1
) (
   // Clock, reset and scan
   input  wire         i_clk,
   input  wire         i_rst,
   input  wire         i_scan,
   // Data
   input  wire [W-1:0] i_d,
   output wire [W-1:0] o_rise,
   output wire [W-1:0] o_fall
);
   reg [W-1:0] prev;

   always @(posedge i_clk) begin
      if (i_rst) begin
         prev <= {W{1'b0}};
      end else if (i_scan) begin
         prev <= i_d;
      end
   end

   assign o_rise = i_d & ~prev;
   assign o_fall = ~i_d & prev;
endmodule

/* File: verilog/slp_top.v */
// Scan logic primitives: selector, one-shots, latch, toggle,
// expression evaluator and keypad pulse unit.
// Assumes inputs synchronous to I_MCLK; I_SCAN pulses once per scan.
//
// Behaviour
// - Selector output follows first input when select ON, else second.
// - Basic one-shot pulses one scan on OFF-to-ON input.
// - Configurable one-shot fires on rising, falling or either edge.
// - Configurable one-shot output is ON one scan only.
// - Start-up firing: none, after cold, after warm, after either.
// - Start-up firing overrides the edge condition on first scan.
// - Latch sets ON with set input, holds until clear.
// - Clear acts only while set is OFF; set wins.
// - Neither input ON: latch holds previous value.
// - Toggle inverts output on each OFF-to-ON input, unless toggle reset is ON.
// - Toggle reset forces output OFF.
// - Evaluator computes one output of eight inputs via AND/OR/XOR/NOT.
// - Each key press gives a one-scan pulse on its output.
// - Up to eight groups, each with four pulse outputs.
// - Presses reach only the outputs of the chosen group.
`timescale 1ns/1ps
`include "slp_consts.vh"
module slp_top #(
   parameter GROUPS = `SLP_KEY_GROUPS,
   parameter GW     = `SLP_GRP_W,
   parameter KEYS   = `SLP_KEYS,
   parameter NODES  = 7
) (
   // Clock, reset, scan and start
   input  wire                I_MCLK,
   input  wire                I_RESET,
   input  wire                I_SCAN,
   input  wire                I_COLD_START,
   input  wire                I_WARM_START,
   // Selector
   input  wire                I_SEL_A,
   input  wire                I_SEL_B,
   input  wire                I_CHOOSE_FIRST_INPUT,
   output reg                 O_SEL_OUT,
   // Basic one-shot
   input  wire                I_TRIG_IN,
   output reg                 O_TRIG_OUT,
   // Configurable one-shot
   input  wire                I_STRIG_IN,
   input  wire [1:0]          I_STRIG_EDGE,
   input  wire [1:0]          I_STRIG_START,
   output reg                 O_STRIG_OUT,
   // Latch
   input  wire                I_LATCH_SET,
   input  wire                I_LATCH_CLR,
   output reg                 O_LATCH_OUT,
   // Toggle flip-flop
   input  wire                I_TOG_IN,
   input  wire                I_TOG_RST,
   output reg                 O_TOG_OUT,
   // Expression evaluator: node k op, operand selects (0-7 input,
   // 8-14 node result), last node is the output
   input  wire [7:0]          I_EXPR_IN,
   input  wire [2*NODES-1:0]  I_EXPR_OP,
   input  wire [4*NODES-1:0]  I_EXPR_SRC_A,
   input  wire [4*NODES-1:0]  I_EXPR_SRC_B,
   output reg                 O_EXPR_OUT,
   // Keypad
   input  wire [KEYS-1:0]     I_FUNCTION_KEY,
   input  wire [GW-1:0]       I_KEY_GROUP,
   output reg  [GROUPS*KEYS-1:0] O_KEY_PULSE
);
   wire            start_any;
   wire            trig_rise;
   wire            strig_rise;
   wire            strig_fall;
   wire            tog_rise;
   wire [KEYS-1:0] key_rise;
   reg        first_cold;
   reg        first_warm;
   reg        strig_edge_hit;
   reg        strig_start_hit;
   reg        next_latch;
   reg [15:0] val;
   reg        a_bit;
   reg        b_bit;
   reg        r_bit;
   reg [GROUPS*KEYS-1:0] next_keys;
   reg [GROUPS-1:0] grp_hit;
   reg        next_sel;
   reg        next_trig;
   reg        next_strig;
   reg        next_tog;
   reg        next_expr;
   integer    k;
   integer    g;
   integer    h;

   // A start wipes edge history, so a high input fires on first scan
   assign start_any = I_RESET | I_COLD_START | I_WARM_START;

   // One edge store per primitive keeps each history separate
   slp_edge #(.W(1)) u_trig_edge (
      .i_clk  (I_MCLK),
      .i_rst  (start_any),
      .i_scan (I_SCAN),
      .i_d    (I_TRIG_IN),
      .o_rise (trig_rise),
      .o_fall ()
   );

   slp_edge #(.W(1)) u_strig_edge (
      .i_clk  (I_MCLK),
      .i_rst  (start_any),
      .i_scan (I_SCAN),
      .i_d    (I_STRIG_IN),
      .o_rise (strig_rise),
      .o_fall (strig_fall)
   );

   slp_edge #(.W(1)) u_tog_edge (
      .i_clk  (I_MCLK),
      .i_rst  (start_any),
      .i_scan (I_SCAN),
      .i_d    (I_TOG_IN),
      .o_rise (tog_rise),
      .o_fall ()
   );

   slp_edge #(.W(KEYS)) u_keys (
      .i_clk  (I_MCLK),
      .i_rst  (start_any),
      .i_scan (I_SCAN),
      .i_d    (I_FUNCTION_KEY),
      .o_rise (key_rise),
      .o_fall ()
   );

   // Start kind is remembered until the first scan consumes it
   always @(posedge I_MCLK) begin
      if (I_RESET) begin
         first_cold <= 1'b0;
         first_warm <= 1'b0;
      end else if (I_COLD_START) begin
         first_cold <= 1'b1;
         first_warm <= 1'b0;
      end else if (I_WARM_START) begin
         first_cold <= 1'b0;
         first_warm <= 1'b1;
      end else if (I_SCAN) begin
         first_cold <= 1'b0;
         first_warm <= 1'b0;
      end
   end

   always @* begin
      case (I_STRIG_EDGE)
         `SLP_EDGE_RISE: strig_edge_hit = strig_rise;
         `SLP_EDGE_FALL: strig_edge_hit = strig_fall;
         `SLP_EDGE_BOTH: strig_edge_hit = strig_rise | strig_fall;
         default:        strig_edge_hit = 1'b0;
      endcase
      case (I_STRIG_START)
         `SLP_START_COLD: strig_start_hit = first_cold;
         `SLP_START_WARM: strig_start_hit = first_warm;
         `SLP_START_ANY:  strig_start_hit = first_cold | first_warm;
         default:         strig_start_hit = 1'b0;
      endcase
   end

   // Set beats clear; neither holds
   always @* begin
      if (I_LATCH_SET) begin
         next_latch = 1'b1;
      end else if (I_LATCH_CLR) begin
         next_latch = 1'b0;
      end else begin
         next_latch = O_LATCH_OUT;
      end
   end

   // Expression as a node list; no forward references, so a
   // node may read inputs or earlier nodes. Bracket nesting is flattened
   // into node order by the configuring side.
   always @* begin
      val = {8'h00, I_EXPR_IN};
      a_bit = 1'b0;
      b_bit = 1'b0;
      r_bit = 1'b0;
      for (k = 0; k < NODES; k = k + 1) begin
         a_bit = val[I_EXPR_SRC_A[4*k +: 4]];
         b_bit = val[I_EXPR_SRC_B[4*k +: 4]];
         case (I_EXPR_OP[2*k +: 2])
            `SLP_OP_AND:  r_bit = a_bit & b_bit;
            `SLP_OP_OR:   r_bit = a_bit | b_bit;
            `SLP_OP_XOR:  r_bit = a_bit ^ b_bit;
            `SLP_OP_NOTA: r_bit = ~a_bit;
            default:      r_bit = 1'b0;
         endcase
         if (k + `SLP_EXPR_INS < `SLP_VAL_W) begin
            val[k + `SLP_EXPR_INS] = r_bit;
         end
      end
   end

   // One-hot group decode; codes past GROUPS-1 select nothing
   always @* begin
      grp_hit = {GROUPS{1'b0}};
      for (h = 0; h < GROUPS; h = h + 1) begin
         if (I_KEY_GROUP == h[GW-1:0]) begin
            grp_hit[h] = 1'b1;
         end
      end
   end

   // Only the chosen group sees key edges
   always @* begin
      next_keys = {GROUPS*KEYS{1'b0}};
      for (g = 0; g < GROUPS; g = g + 1) begin
         if (grp_hit[g]) begin
            next_keys[g*KEYS +: KEYS] = key_rise;
         end
      end
   end

   // Next values, taken only on a scan edge
   // Toggle reset is seen on scans only; a pulse between scans is lost
   always @* begin
      next_sel   = I_CHOOSE_FIRST_INPUT ? I_SEL_A : I_SEL_B;
      next_trig  = trig_rise;
      next_strig = strig_start_hit | strig_edge_hit;
      if (I_TOG_RST) begin
         next_tog = 1'b0;
      end else if (tog_rise) begin
         next_tog = ~O_TOG_OUT;
      end else begin
         next_tog = O_TOG_OUT;
      end
      next_expr  = val[NODES + `SLP_EXPR_INS - 1];
   end

   // Selector output register
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_SEL_OUT <= 1'b0;
      end else if (I_SCAN) begin
         O_SEL_OUT <= next_sel;
      end
   end

   // Basic one-shot register
   // Pulse lasts a whole scan period, not a single clock
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_TRIG_OUT <= 1'b0;
      end else if (I_SCAN) begin
         O_TRIG_OUT <= next_trig;
      end
   end

   // Configurable one-shot register
   // Start-up firing wins; an edge on that same scan is absorbed
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_STRIG_OUT <= 1'b0;
      end else if (I_SCAN) begin
         O_STRIG_OUT <= next_strig;
      end
   end

   // Latch state
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_LATCH_OUT <= 1'b0;
      end else if (I_SCAN) begin
         O_LATCH_OUT <= next_latch;
      end
   end

   // Toggle state
   // A start clears it as well as its own reset input
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_TOG_OUT <= 1'b0;
      end else if (I_SCAN) begin
         O_TOG_OUT <= next_tog;
      end
   end

   // Expression result
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_EXPR_OUT <= 1'b0;
      end else if (I_SCAN) begin
         O_EXPR_OUT <= next_expr;
      end
   end

   // Keypad pulses
   // A key held across scans pulses only once
   always @(posedge I_MCLK) begin
      if (start_any) begin
         O_KEY_PULSE <= {GROUPS*KEYS{1'b0}};
      end else if (I_SCAN) begin
         O_KEY_PULSE <= next_keys;
      end
   end
endmodule
